//--- hdl/lalwu_consts.svh
// constants of the logical AND long/word unit
`ifndef LALWU_CONSTS_SVH
`define LALWU_CONSTS_SVH
// register byte offsets
`define LALWU_ADR_OPCODE    8'h00
`define LALWU_ADR_STATUS    8'h04
`define LALWU_ADR_FLAGS     8'h08
`define LALWU_ADR_CTRL      8'h0C
`define LALWU_ADR_SLOT_BASE 8'h20
`define LALWU_ADR_SLOT_END  8'h60
// status fields
`define LALWU_ST_OPC_LSB    0
`define LALWU_ST_CNT_LSB    16
`define LALWU_ST_ILLEGAL    24
// condition code byte positions
`define LALWU_FLG_C         0
`define LALWU_FLG_V         1
`define LALWU_FLG_Z         2
`define LALWU_FLG_N         3
`define LALWU_FLAGS_RST     16'h0000
// slot map: 0-3 accumulators, 4-5 long registers, 6-7 word registers
`define LALWU_NUM_SLOTS     8
`define LALWU_FIRST_REG_SLOT  3'h4
`define LALWU_FIRST_HALF_SLOT 3'h6
// opcode fields
`define LALWU_OPC_IMM_LONG  6'h11
`define LALWU_OPC_IMM_WORD  6'h15
`define LALWU_OPC_REG       6'h1E
`define LALWU_IMM_MARK      2'h3
`define LALWU_NIB_LONG      4'hC
`define LALWU_NIB_WORD      4'h8
`define LALWU_EXEC_CYCLES   1
`endif

//--- hdl/lalwu_pkg.sv
// types and shared helpers of the logical AND long/word unit
`default_nettype none
`include "lalwu_consts.svh"
package lalwu_pkg;
  typedef enum logic [1:0] {LALWU_FORM_NONE, LALWU_FORM_LONG, LALWU_FORM_WORD} lalwu_form_t;
  typedef enum logic {LALWU_SRC_REG, LALWU_SRC_IMM} lalwu_src_t;

  typedef struct packed {
    logic [`LALWU_NUM_SLOTS-1:0][35:0] slots;
    logic [15:0]                       flags;
    logic                              sat_en;
    logic                              illegal;
    logic [7:0]                        exec_count;
    logic [15:0]                       last_opcode;
    logic                              ack;
    logic [31:0]                       rdata;
  } lalwu_state_t;

  function automatic logic lalwu_is_accum(input logic [2:0] sel);
    return sel < `LALWU_FIRST_REG_SLOT;
  endfunction : lalwu_is_accum
endpackage : lalwu_pkg
`default_nettype wire

//--- hdl/lalwu_op_if.sv
// decoded instruction fields passed from decoder to AND datapath
`timescale 1ns/10ps
`default_nettype none
interface lalwu_op_if;
  import lalwu_pkg::*;
  logic [15:0] opcode;
  lalwu_form_t form;
  lalwu_src_t  src_kind;
  logic [2:0]  dst_sel;
  logic [2:0]  src_sel;
  logic [4:0]  imm;
  modport dec (input opcode, output form, src_kind, dst_sel, src_sel, imm);
  modport exe (input form, src_kind, dst_sel, src_sel, imm);
endinterface : lalwu_op_if
`default_nettype wire

//--- hdl/lalwu_decode.sv
// opcode decoder for the long and word AND forms
`timescale 1ns/10ps
`default_nettype none
module lalwu_decode
  import lalwu_pkg::*;
(
  // decoded fields
  lalwu_op_if.dec op
);
  always_comb begin
    op.form     = LALWU_FORM_NONE;
    op.src_kind = LALWU_SRC_REG;
    op.dst_sel  = op.opcode[9:7];
    op.src_sel  = op.opcode[6:4];
    op.imm      = op.opcode[4:0];
    if (op.opcode[6:5] == `LALWU_IMM_MARK && op.opcode[15:10] == `LALWU_OPC_IMM_LONG) begin
      op.form     = LALWU_FORM_LONG;
      op.src_kind = LALWU_SRC_IMM;
    end else if (op.opcode[6:5] == `LALWU_IMM_MARK
                 && op.opcode[15:10] == `LALWU_OPC_IMM_WORD) begin
      op.form     = LALWU_FORM_WORD;
      op.src_kind = LALWU_SRC_IMM;
    end else if (op.opcode[15:10] == `LALWU_OPC_REG && op.opcode[3:0] == `LALWU_NIB_LONG) begin
      op.form = LALWU_FORM_LONG;
    end else if (op.opcode[15:10] == `LALWU_OPC_REG && op.opcode[3:0] == `LALWU_NIB_WORD) begin
      op.form = LALWU_FORM_WORD;
    end
  end
endmodule : lalwu_decode
`default_nettype wire

//--- hdl/lalwu_and_core.sv
// combinational AND datapath with condition code update
`timescale 1ns/10ps
`default_nettype none
module lalwu_and_core
  import lalwu_pkg::*;
(
  // decoded instruction
  lalwu_op_if.exe    op,
  // operands and flags
  input  wire logic [35:0] dst_val_in,
  input  wire logic [35:0] src_val_in,
  input  wire logic [15:0] flags_in,
  // results
  output logic      [35:0] res_out,
  output logic      [15:0] flags_out
);
  logic [31:0] src32;
  logic [15:0] src16;

  always_comb begin
    res_out   = dst_val_in;
    flags_out = flags_in;
    src32     = 32'h0000_0000;
    src16     = 16'h0000;
    unique case (op.form)
      LALWU_FORM_LONG: begin
        if (op.src_kind == LALWU_SRC_IMM) src32 = {27'h000_0000, op.imm};
        else if (op.src_sel >= `LALWU_FIRST_HALF_SLOT) src32 = {src_val_in[15:0], 16'h0000};
        else src32 = src_val_in[31:0];
        res_out[31:0]          = dst_val_in[31:0] & src32;
        // flags from bit 31 and low 32
        flags_out[`LALWU_FLG_N] = res_out[31];
        flags_out[`LALWU_FLG_Z] = res_out[31:0] == 32'h0000_0000;
      end
      LALWU_FORM_WORD: begin
        if (op.src_kind == LALWU_SRC_IMM) src16 = {11'h000, op.imm};
        else if (lalwu_is_accum(op.src_sel)) src16 = src_val_in[31:16];
        else src16 = src_val_in[15:0];
        if (lalwu_is_accum(op.dst_sel)) begin
          res_out[31:16]          = dst_val_in[31:16] & src16;
          flags_out[`LALWU_FLG_N] = res_out[31];
          flags_out[`LALWU_FLG_Z] = res_out[31:16] == 16'h0000;
        end else begin
          res_out[15:0]           = dst_val_in[15:0] & src16;
          flags_out[`LALWU_FLG_N] = res_out[15];
          flags_out[`LALWU_FLG_Z] = res_out[15:0] == 16'h0000;
        end
      end
      LALWU_FORM_NONE: begin
      end
    endcase
    if (op.form != LALWU_FORM_NONE) flags_out[`LALWU_FLG_V] = 1'b0;
  end
endmodule : lalwu_and_core
`default_nettype wire

//--- hdl/lalwu_top.sv
// logical AND long/word unit with classic Wishbone register access
`timescale 1ns/10ps
`default_nettype none
module lalwu_top
  import lalwu_pkg::*;
(
  // clock and reset
  input  wire logic        clock_in,
  input  wire logic        rst_in,
  // wishbone slave
  input  wire logic        wb_cyc_in,
  input  wire logic        wb_stb_in,
  input  wire logic        wb_we_in,
  input  wire logic [7:0]  wb_adr_in,
  input  wire logic [3:0]  wb_sel_in,
  input  wire logic [31:0] wb_dat_in,
  output logic      [31:0] wb_dat_out,
  output logic             wb_ack_out,
  // condition code byte
  output logic      [7:0]  cond_code_out
);
  lalwu_state_t s;
  lalwu_state_t next_s;

  logic        bus_req;
  logic        bus_wr;
  logic [7:0]  adr_word;
  logic        exe_go;
  logic [35:0] cur_dst;
  logic [35:0] cur_src;
  logic [35:0] core_res;
  logic [15:0] core_flags;
  logic [31:0] flag_word;

  lalwu_op_if op ();

  function automatic logic [31:0] lalwu_merge(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  sel);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) r[8*i +: 8] = new_v[8*i +: 8];
    end
    return r;
  endfunction : lalwu_merge

  function automatic logic lalwu_slot_hit(input logic [7:0] a);
    return a >= `LALWU_ADR_SLOT_BASE && a < `LALWU_ADR_SLOT_END;
  endfunction : lalwu_slot_hit

  function automatic logic [2:0] lalwu_slot_idx(input logic [7:0] a);
    logic [7:0] d;
    d = a - `LALWU_ADR_SLOT_BASE;
    return d[5:3];
  endfunction : lalwu_slot_idx

  function automatic logic [31:0] lalwu_read(input lalwu_state_t st, input logic [7:0] a);
    logic [31:0] r;
    logic [35:0] sl;
    r  = 32'h0000_0000;
    sl = st.slots[lalwu_slot_idx(a)];
    if (a == `LALWU_ADR_OPCODE) begin
      r[15:0] = st.last_opcode;
    end else if (a == `LALWU_ADR_STATUS) begin
      r[`LALWU_ST_OPC_LSB +: 16] = st.last_opcode;
      r[`LALWU_ST_CNT_LSB +: 8]  = st.exec_count;
      r[`LALWU_ST_ILLEGAL]       = st.illegal;
    end else if (a == `LALWU_ADR_FLAGS) begin
      r[15:0] = st.flags;
    end else if (a == `LALWU_ADR_CTRL) begin
      r[0] = st.sat_en;
    end else if (lalwu_slot_hit(a)) begin
      if (a[2]) r[3:0] = sl[35:32];
      else r = sl[31:0];
    end
    return r;
  endfunction : lalwu_read

  assign bus_req   = wb_cyc_in && wb_stb_in;
  // writes land on the edge where the master sees ack
  assign bus_wr    = bus_req && s.ack && wb_we_in;
  assign adr_word  = {wb_adr_in[7:2], 2'b00};
  assign exe_go    = bus_wr && adr_word == `LALWU_ADR_OPCODE;
  assign op.opcode = wb_dat_in[15:0];
  assign cur_dst   = s.slots[op.dst_sel];
  assign cur_src   = s.slots[op.src_sel];
  assign flag_word = lalwu_merge({16'h0000, s.flags}, wb_dat_in, wb_sel_in);

  lalwu_decode u_decode (
    .op (op)
  );

  lalwu_and_core u_core (
    .op         (op),
    .dst_val_in (cur_dst),
    .src_val_in (cur_src),
    .flags_in   (s.flags),
    .res_out    (core_res),
    .flags_out  (core_flags)
  );

  always_comb begin
    next_s     = s;
    next_s.ack = 1'b0;
    // one wait state: ack and read data both come from flops
    if (bus_req && !s.ack) begin
      next_s.ack   = 1'b1;
      next_s.rdata = lalwu_read(s, adr_word);
    end
    if (bus_wr) begin
      if (adr_word == `LALWU_ADR_OPCODE) begin
        next_s.last_opcode = wb_dat_in[15:0];
        if (op.form != LALWU_FORM_NONE) begin
          next_s.slots[op.dst_sel] = core_res;
          next_s.flags             = core_flags;
          next_s.exec_count        = s.exec_count + 8'h01;
        end else begin
          next_s.illegal = 1'b1;
        end
      end else if (adr_word == `LALWU_ADR_STATUS) begin
        // write one to clear; no set can share this cycle
        if (wb_sel_in[3] && wb_dat_in[`LALWU_ST_ILLEGAL]) next_s.illegal = 1'b0;
      end else if (adr_word == `LALWU_ADR_FLAGS) begin
        next_s.flags = flag_word[15:0];
      end else if (adr_word == `LALWU_ADR_CTRL) begin
        if (wb_sel_in[0]) next_s.sat_en = wb_dat_in[0];
      end else if (lalwu_slot_hit(adr_word)) begin
        if (!adr_word[2]) begin
          next_s.slots[lalwu_slot_idx(adr_word)][31:0] =
            lalwu_merge(s.slots[lalwu_slot_idx(adr_word)][31:0], wb_dat_in, wb_sel_in);
        end else if (lalwu_is_accum(lalwu_slot_idx(adr_word)) && wb_sel_in[0]) begin
          // only accumulators own an extension nibble
          next_s.slots[lalwu_slot_idx(adr_word)][35:32] = wb_dat_in[3:0];
        end
      end
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign wb_ack_out    = s.ack;
  assign wb_dat_out    = s.rdata;
  assign cond_code_out = s.flags[7:0];

  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (rst_in);

  a_long_reg_and: assert property (
    exe_go && op.form == LALWU_FORM_LONG && op.src_kind == LALWU_SRC_REG
      && op.src_sel >= `LALWU_FIRST_REG_SLOT && op.src_sel < `LALWU_FIRST_HALF_SLOT
    |=> s.slots[$past(op.dst_sel)][31:0] == ($past(cur_dst[31:0]) & $past(cur_src[31:0])))
    else $error("long and result wrong");

  a_long_ext_kept: assert property (
    exe_go && op.form == LALWU_FORM_LONG && lalwu_is_accum(op.dst_sel)
    |=> s.slots[$past(op.dst_sel)][35:32] == $past(cur_dst[35:32]))
    else $error("long and touched extension");

  a_long_half_widen: assert property (
    exe_go && op.form == LALWU_FORM_LONG && op.src_kind == LALWU_SRC_REG
      && op.src_sel >= `LALWU_FIRST_HALF_SLOT
    |=> s.slots[$past(op.dst_sel)][15:0] == 16'h0000
      && s.slots[$past(op.dst_sel)][31:16] == ($past(cur_dst[31:16]) & $past(cur_src[15:0])))
    else $error("word source not widened");

  a_imm_zero_ext: assert property (
    exe_go && op.form == LALWU_FORM_LONG && op.src_kind == LALWU_SRC_IMM
    |=> s.slots[$past(op.dst_sel)][31:5] == 27'h000_0000
      && s.slots[$past(op.dst_sel)][4:0] == ($past(cur_dst[4:0]) & $past(op.imm)))
    else $error("immediate not zero extended");

  a_no_saturate: assert property (
    exe_go && s.sat_en && op.form == LALWU_FORM_LONG && op.src_kind == LALWU_SRC_REG
      && op.src_sel < `LALWU_FIRST_HALF_SLOT
    |=> s.slots[$past(op.dst_sel)][31:0] == ($past(cur_dst[31:0]) & $past(cur_src[31:0])))
    else $error("result limited under saturation");

  a_long_neg_flag: assert property (
    exe_go && op.form == LALWU_FORM_LONG
    |=> s.flags[`LALWU_FLG_N] == s.slots[$past(op.dst_sel)][31])
    else $error("long negative flag wrong");

  a_long_zero_flag: assert property (
    exe_go && op.form == LALWU_FORM_LONG
    |=> s.flags[`LALWU_FLG_Z] == (s.slots[$past(op.dst_sel)][31:0] == 32'h0000_0000))
    else $error("long zero flag wrong");

  a_word_reg_and: assert property (
    exe_go && op.form == LALWU_FORM_WORD && op.src_kind == LALWU_SRC_REG
      && !lalwu_is_accum(op.dst_sel) && !lalwu_is_accum(op.src_sel)
    |=> s.slots[$past(op.dst_sel)][15:0] == ($past(cur_dst[15:0]) & $past(cur_src[15:0])))
    else $error("word and result wrong");

  a_word_acc_keep: assert property (
    exe_go && op.form == LALWU_FORM_WORD && lalwu_is_accum(op.dst_sel)
      && op.src_kind == LALWU_SRC_IMM
    |=> s.slots[$past(op.dst_sel)][15:0] == $past(cur_dst[15:0])
      && s.slots[$past(op.dst_sel)][35:32] == $past(cur_dst[35:32])
      && s.slots[$past(op.dst_sel)][31:21] == 11'h000)
    else $error("word and touched other accumulator bits");

  a_word_neg_flag: assert property (
    exe_go && op.form == LALWU_FORM_WORD
    |=> s.flags[`LALWU_FLG_N] == (lalwu_is_accum($past(op.dst_sel))
          ? s.slots[$past(op.dst_sel)][31] : s.slots[$past(op.dst_sel)][15]))
    else $error("word negative flag wrong");

  a_word_zero_flag: assert property (
    exe_go && op.form == LALWU_FORM_WORD
    |=> s.flags[`LALWU_FLG_Z] == (lalwu_is_accum($past(op.dst_sel))
          ? s.slots[$past(op.dst_sel)][31:16] == 16'h0000
          : s.slots[$past(op.dst_sel)][15:0] == 16'h0000))
    else $error("word zero flag wrong");

  a_one_cycle_exec: assert property (
    exe_go && op.form != LALWU_FORM_NONE
    |=> s.exec_count == $past(s.exec_count) + 8'h01 && !s.ack
      ##1 $stable(s.slots) || s.ack)
    else $error("execute not single cycle");

  a_imm_decode: assert property (
    exe_go && wb_dat_in[6:5] == `LALWU_IMM_MARK && wb_dat_in[15:10] == `LALWU_OPC_IMM_LONG
    |-> op.form == LALWU_FORM_LONG && op.src_kind == LALWU_SRC_IMM
      && op.imm == wb_dat_in[4:0] && op.dst_sel == wb_dat_in[9:7])
    else $error("immediate decode wrong");

  a_flags_kept: assert property (
    exe_go && op.form != LALWU_FORM_NONE
    |=> !s.flags[`LALWU_FLG_V] && s.flags[15:4] == $past(s.flags[15:4])
      && s.flags[`LALWU_FLG_C] == $past(s.flags[`LALWU_FLG_C]))
    else $error("untouched flags changed");

  a_reg_decode: assert property (
    exe_go && wb_dat_in[15:10] == `LALWU_OPC_REG && wb_dat_in[3:0] == `LALWU_NIB_WORD
    |-> op.form == LALWU_FORM_WORD && op.src_kind == LALWU_SRC_REG
      && op.src_sel == wb_dat_in[6:4] && op.dst_sel == wb_dat_in[9:7])
    else $error("register decode wrong");

  a_illegal_sticky: assert property (
    exe_go && op.form == LALWU_FORM_NONE
    |=> s.illegal && s.exec_count == $past(s.exec_count)
      && s.slots == $past(s.slots))
    else $error("illegal opcode changed state");

  a_ack_pulse: assert property (
    s.ack |=> !s.ack)
    else $error("ack held two cycles");

  a_ack_follows: assert property (
    bus_req && !s.ack |=> s.ack)
    else $error("request not acknowledged");

  a_ack_idle: assert property (
    !bus_req |=> !s.ack)
    else $error("ack without request");

  a_rdata_kept: assert property (
    !(bus_req && !s.ack) |=> $stable(s.rdata))
    else $error("read data changed outside a read");

  a_ctrl_read: assert property (
    bus_req && !s.ack && adr_word == `LALWU_ADR_CTRL
    |=> s.rdata == {31'h0000_0000, $past(s.sat_en)})
    else $error("control read wrong");

  a_long_reg_dst: assert property (
    exe_go && op.form == LALWU_FORM_LONG && !lalwu_is_accum(op.dst_sel)
    |=> s.slots[$past(op.dst_sel)][35:32] == $past(cur_dst[35:32]))
    else $error("long and touched register top bits");

  a_word_acc_src: assert property (
    exe_go && op.form == LALWU_FORM_WORD && op.src_kind == LALWU_SRC_REG
      && !lalwu_is_accum(op.dst_sel) && lalwu_is_accum(op.src_sel)
    |=> s.slots[$past(op.dst_sel)][15:0] == ($past(cur_dst[15:0]) & $past(cur_src[31:16])))
    else $error("word and from accumulator wrong");

  a_word_reg_upper: assert property (
    exe_go && op.form == LALWU_FORM_WORD && !lalwu_is_accum(op.dst_sel)
    |=> s.slots[$past(op.dst_sel)][35:16] == $past(cur_dst[35:16]))
    else $error("word and touched upper register bits");

  a_word_acc_reg: assert property (
    exe_go && op.form == LALWU_FORM_WORD && op.src_kind == LALWU_SRC_REG
      && lalwu_is_accum(op.dst_sel) && !lalwu_is_accum(op.src_sel)
    |=> s.slots[$past(op.dst_sel)][31:16] == ($past(cur_dst[31:16]) & $past(cur_src[15:0]))
      && s.slots[$past(op.dst_sel)][15:0] == $past(cur_dst[15:0]))
    else $error("word and into accumulator wrong");

  a_sat_word: assert property (
    exe_go && s.sat_en && op.form == LALWU_FORM_WORD && op.src_kind == LALWU_SRC_IMM
      && lalwu_is_accum(op.dst_sel)
    |=> s.slots[$past(op.dst_sel)][31:16]
        == ($past(cur_dst[31:16]) & {11'h000, $past(op.imm)}))
    else $error("word result limited under saturation");

  a_imm_word_dec: assert property (
    exe_go && wb_dat_in[6:5] == `LALWU_IMM_MARK && wb_dat_in[15:10] == `LALWU_OPC_IMM_WORD
    |-> op.form == LALWU_FORM_WORD && op.src_kind == LALWU_SRC_IMM
      && op.imm == wb_dat_in[4:0] && op.dst_sel == wb_dat_in[9:7])
    else $error("word immediate decode wrong");

  a_reg_long_dec: assert property (
    exe_go && wb_dat_in[15:10] == `LALWU_OPC_REG && wb_dat_in[3:0] == `LALWU_NIB_LONG
    |-> op.form == LALWU_FORM_LONG && op.src_kind == LALWU_SRC_REG
      && op.src_sel == wb_dat_in[6:4] && op.dst_sel == wb_dat_in[9:7])
    else $error("long register decode wrong");

  a_last_opcode: assert property (
    exe_go |=> s.last_opcode == $past(wb_dat_in[15:0]))
    else $error("last opcode not recorded");

  a_illegal_flags: assert property (
    exe_go && op.form == LALWU_FORM_NONE |=> s.flags == $past(s.flags))
    else $error("illegal opcode changed flags");

  a_illegal_clear: assert property (
    bus_wr && adr_word == `LALWU_ADR_STATUS && wb_sel_in[3] && wb_dat_in[`LALWU_ST_ILLEGAL]
    |=> !s.illegal)
    else $error("illegal flag not cleared");

  a_count_quiet: assert property (
    !exe_go |=> s.exec_count == $past(s.exec_count))
    else $error("execute count moved without execute");
endmodule : lalwu_top
`default_nettype wire

//--- bench/lalwu_wb_host.sv
// wishbone master model standing in for the core side of the unit
`timescale 1ns/10ps
`default_nettype none
module lalwu_wb_host (
  // clock
  input  wire logic        clock_in,
  // wishbone master
  output var  logic        wb_cyc_out,
  output var  logic        wb_stb_out,
  output var  logic        wb_we_out,
  output var  logic [7:0]  wb_adr_out,
  output var  logic [3:0]  wb_sel_out,
  output var  logic [31:0] wb_dat_out,
  input  wire logic [31:0] wb_dat_in,
  input  wire logic        wb_ack_in
);
  initial begin
    wb_cyc_out = 1'b0;
    wb_stb_out = 1'b0;
    wb_we_out  = 1'b0;
    wb_adr_out = 8'h00;
    wb_sel_out = 4'h0;
    wb_dat_out = 32'h0000_0000;
  end

  // one classic cycle, entered at a rising edge; ok stays low if ack never comes
  task automatic access(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                        input logic [3:0] sel, output logic [31:0] rdat, output logic ok);
    int n;
    ok = 1'b0;
    rdat = 32'h0000_0000;
    wb_cyc_out <= 1'b1;
    wb_stb_out <= 1'b1;
    wb_we_out  <= we;
    wb_adr_out <= adr;
    wb_sel_out <= sel;
    wb_dat_out <= dat;
    for (n = 0; n < 20 && ok !== 1'b1; n++) begin
      @(posedge clock_in);
      if (wb_ack_in === 1'b1) begin
        ok = 1'b1;
        rdat = wb_dat_in;
      end
    end
    wb_cyc_out <= 1'b0;
    wb_stb_out <= 1'b0;
    wb_we_out  <= 1'b0;
    // released data must not look like the last value
    wb_dat_out <= ~dat;
    @(posedge clock_in);
  endtask : access
endmodule : lalwu_wb_host
`default_nettype wire

//--- bench/testbench.sv
// self-checking bench of the logical AND long/word unit
`timescale 1ns/10ps
`default_nettype none
`include "lalwu_consts.svh"
`define CHECK(name, exp, got) begin n_tests++; if ((got) !== (exp)) begin miscompares++; \
  $display("wrong value %s expected %h seen %h", name, exp, got); end end
module testbench;
  logic        clock;
  logic        rst;
  logic        cyc, stb, we, ack;
  logic [7:0]  adr;
  logic [7:0]  condition_code_byte;
  logic [3:0]  sel;
  logic [31:0] dat_w, dat_r;
  int          miscompares = 0;
  int          n_tests = 0;

  typedef struct {
    logic [2:0]  dst;
    logic [35:0] dv;
    logic [2:0]  src;
    logic [31:0] sv;
    logic [15:0] opc;
    logic [35:0] res;
    logic [1:0]  nz;
  } lalwu_row_t;

  // dst, its value, src, its value, opcode, expected dst, expected n and z
  lalwu_row_t rows [8] = '{
    '{3'h0, 36'h6_1234_5678, 3'h4, 32'h7F00_00FF, 16'h784C, 36'h6_1200_0078, 2'h0},
    '{3'h1, 36'h9_FFFF_FFFF, 3'h6, 32'h0000_F0F0, 16'h78EC, 36'h9_F0F0_0000, 2'h2},
    '{3'h2, 36'h5_FFFF_FFE0, 3'h4, 32'hFFFF_FFFF, 16'h457F, 36'h5_0000_0000, 2'h1},
    '{3'h0, 36'h6_1234_5678, 3'h6, 32'h0000_7F00, 16'h7868, 36'h6_1200_5678, 2'h0},
    '{3'h3, 36'hA_8000_FFFF, 3'h4, 32'hFFFF_FFFF, 16'h55FF, 36'hA_0000_FFFF, 2'h1},
    '{3'h7, 36'h0_0000_F00F, 3'h6, 32'h0000_8F00, 16'h7BE8, 36'h0_0000_8000, 2'h2},
    '{3'h5, 36'h0_FFFF_FFF0, 3'h4, 32'hFFFF_FFFF, 16'h46E0, 36'h0_0000_0000, 2'h1},
    '{3'h4, 36'h0_ABCD_F0F0, 3'h1, 32'h0F0F_0000, 16'h7A18, 36'h0_ABCD_0000, 2'h1}};

  lalwu_wb_host host (.clock_in(clock), .wb_cyc_out(cyc), .wb_stb_out(stb), .wb_we_out(we),
    .wb_adr_out(adr), .wb_sel_out(sel), .wb_dat_out(dat_w), .wb_dat_in(dat_r),
    .wb_ack_in(ack));

  lalwu_top uut (.clock_in(clock), .rst_in(rst), .wb_cyc_in(cyc), .wb_stb_in(stb),
    .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(dat_w),
    .wb_dat_out(dat_r), .wb_ack_out(ack), .cond_code_out(condition_code_byte));

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : summarize

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s, output logic [31:0] q);
    logic ok;
    host.access(w, a, d, s, q, ok);
    if (ok !== 1'b1) begin
      miscompares++;
      $display("wrong value bus ack expected 1 seen 0");
      summarize();
    end
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] q;
    bus(1'b1, a, d, s, q);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    bus(1'b0, a, 32'h0000_0000, 4'hF, q);
  endtask : rd

  task automatic put_slot(input logic [2:0] i, input logic [35:0] v);
    wr(`LALWU_ADR_SLOT_BASE + {i, 3'h0}, v[31:0], 4'hF);
    if (i < 3'h4) wr(`LALWU_ADR_SLOT_BASE + 8'h04 + {i, 3'h0}, {28'h000_0000, v[35:32]}, 4'hF);
  endtask : put_slot

  task automatic get_slot(input logic [2:0] i, output logic [35:0] v);
    logic [31:0] lo, hi;
    hi = 32'h0000_0000;
    rd(`LALWU_ADR_SLOT_BASE + {i, 3'h0}, lo);
    if (i < 3'h4) rd(`LALWU_ADR_SLOT_BASE + 8'h04 + {i, 3'h0}, hi);
    v = {hi[3:0], lo};
  endtask : get_slot

  initial begin
    logic [31:0] v, e;
    logic [35:0] s;
    rst = 1'b1;
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    `CHECK("ccr after reset", 8'h00, condition_code_byte)
    rd(`LALWU_ADR_FLAGS, v);
    `CHECK("flags after reset", 32'h0000_0000, v)
    rd(`LALWU_ADR_STATUS, v);
    `CHECK("status after reset", 32'h0000_0000, v)
    rd(8'h10, v);
    `CHECK("unmapped read", 32'h0000_0000, v)
    // saturation on for every row: results must still be plain AND
    wr(`LALWU_ADR_CTRL, 32'h0000_0001, 4'hF);
    rd(`LALWU_ADR_CTRL, v);
    `CHECK("ctrl", 32'h0000_0001, v)
    foreach (rows[k]) begin
      put_slot(rows[k].src, {4'h0, rows[k].sv});
      put_slot(rows[k].dst, rows[k].dv);
      // carry, overflow and upper flags preset so a stray write shows
      wr(`LALWU_ADR_FLAGS, 32'h0000_A5F3, 4'hF);
      wr(`LALWU_ADR_OPCODE, {16'h0000, rows[k].opc}, 4'hF);
      get_slot(rows[k].dst, s);
      `CHECK("dst slot", rows[k].res, s)
      e = {16'h0000, 8'hA5, 4'hF, rows[k].nz, 2'h1};
      rd(`LALWU_ADR_FLAGS, v);
      `CHECK("flags", e, v)
      `CHECK("ccr port", e[7:0], condition_code_byte)
    end
    rd(`LALWU_ADR_STATUS, v);
    `CHECK("status count", 32'h0008_7A18, v)
    // immediate pattern without bits 6 and 5 set is no AND
    wr(`LALWU_ADR_OPCODE, 32'h0000_4400, 4'hF);
    get_slot(3'h0, s);
    `CHECK("slot kept", 36'h6_1200_5678, s)
    rd(`LALWU_ADR_STATUS, v);
    `CHECK("illegal set", 16'h0108, v[31:16])
    wr(`LALWU_ADR_STATUS, 32'h0100_0000, 4'h8);
    rd(`LALWU_ADR_STATUS, v);
    `CHECK("illegal cleared", 16'h0008, v[31:16])
    // second reset in mid-run
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    `CHECK("ccr mid reset", 8'h00, condition_code_byte)
    rst <= 1'b0;
    @(posedge clock);
    get_slot(3'h0, s);
    `CHECK("slot after reset", 36'h0_0000_0000, s)
    summarize();
  end
endmodule : testbench
`default_nettype wire
